//--- hw/apc_mode_decode.sv
// Decoder that checks a processing mode code and gives its one-hot form.
`timescale 1ns/100ps
module apc_mode_decode (
  input  wire logic [2:0] code,
  output logic            legal,
  output logic      [2:0] oneHot
);
  always_comb begin
    legal  = 1'b1;
    oneHot = 3'h0;
    case (code)
      apc_pkg::MODE_P34: begin
        oneHot = 3'h4;
      end
      apc_pkg::MODE_P2: begin
        oneHot = 3'h2;
      end
      apc_pkg::MODE_P1: begin
        oneHot = 3'h1;
      end
      default: begin
        legal = 1'b0;
      end
    endcase
  end
endmodule : apc_mode_decode

//--- hw/apc_pkg.sv
// Package with offsets, field positions, reset values and state type of the power control page.
// Contract
// - Page pointer takes 0 to 255 and selects the page of later accesses.
// - Reference bit D4 set enables master reference, cleared powers it down, resets zero.
// - Reference bit D3 cleared keeps power-on-reset running, set shuts it down.
// - Reference bit D1 cleared keeps regulator bandgap powered, set powers it down.
// - Regulator bits D5-D4 pick 1.8, 1.6, 1.7 or 1.5 V output.
// - Regulator bit D3 set powers down PLL and level shifters; resets to one.
// - Regulator bit D1 reads one while a supply short circuit is detected.
// - Regulator bit D0 reads the level of the regulator select pin.
// - Playback bit D5 picks low-power DAC when cleared, high performance when set.
// - Mode field D4-D2 codes 000, 001, 010 only; host never writes 011-111.
// - Gain bit D7 set disables soft-stepping of all DAC gain stages.
// - Gain bit D6 set doubles the soft-stepping interval of DAC gain stages.
// - Driver bit D5 set powers the headphone output up.
// - Driver bit D1 set enables the left analog input.
// - Driver bit D0 set enables the right analog input.
// - Common-mode bit D6 picks 0.9 V when cleared, 0.75 V when set.
// - Common-mode bit D2 set halves headphone drive strength.
package apc_pkg;
  localparam logic [7:0] PAGE_THIS    = 8'h01;
  localparam logic [7:0] OFF_PAGE     = 8'h00;
  localparam logic [7:0] OFF_REF      = 8'h01;
  localparam logic [7:0] OFF_LDO      = 8'h02;
  localparam logic [7:0] OFF_PLAY     = 8'h03;
  localparam logic [7:0] OFF_RSVD_LO  = 8'h04;
  localparam logic [7:0] OFF_RSVD_HI  = 8'h07;
  localparam logic [7:0] OFF_GAIN     = 8'h08;
  localparam logic [7:0] OFF_DRV      = 8'h09;
  localparam logic [7:0] OFF_CM       = 8'h0A;

  localparam int BIT_REF_MASTER = 4;
  localparam int BIT_REF_POR    = 3;
  localparam int BIT_REF_REGULATOR_BANDGAP   = 1;
  localparam int LDO_LVL_LSB    = 4;
  localparam int BIT_LDO_LS     = 3;
  localparam int BIT_LDO_RSVD   = 2;
  localparam int BIT_LDO_SC     = 1;
  localparam int BIT_REGULATOR_SELECT_PIN    = 0;
  localparam int BIT_PLAY_HP    = 5;
  localparam int PLAY_MODE_LSB  = 2;
  localparam int BIT_GAIN_SSDIS = 7;
  localparam int BIT_GAIN_SSDBL = 6;
  localparam int BIT_DRV_HP     = 5;
  localparam int BIT_DRV_ANALOG_INPUT_LEFT   = 1;
  localparam int BIT_DRV_ANALOG_INPUT_RIGHT   = 0;
  localparam int BIT_CM_LEVEL   = 6;
  localparam int BIT_CM_HALF    = 2;

  localparam logic [7:0] RST_PAGE     = 8'h00;
  localparam logic [7:0] RST_READ     = 8'h00;
  localparam logic [1:0] RST_LDO_LVL  = 2'h0;
  localparam logic       RST_LDO_LS   = 1'b1;
  localparam logic       RST_LDO_RSVD = 1'b1;
  localparam logic       RST_CTRL_BIT = 1'b0;
  localparam logic [2:0] RST_MODE     = 3'h0;

  localparam logic [2:0] MODE_P34 = 3'h0;
  localparam logic [2:0] MODE_P2  = 3'h1;
  localparam logic [2:0] MODE_P1  = 3'h2;

  typedef struct packed {
    logic [7:0] page;
    logic       refMaster;
    logic       porDown;
    logic       bgapDown;
    logic [1:0] ldoLevel;
    logic       lsDown;
    logic       dacHighPerf;
    logic [2:0] mode;
    logic [2:0] modeHot;
    logic       ssDisable;
    logic       ssDouble;
    logic       hpUp;
    logic       ainLeft;
    logic       ainRight;
    logic       cmLow;
    logic       hpHalf;
    logic [7:0] rdData;
    logic       rdValid;
  } apc_state_t;
endpackage : apc_pkg

//--- hw/apc_regs.sv
// Register bank of the power control page with its status inputs and control outputs.
`timescale 1ns/100ps
module apc_regs #(
  parameter logic [7:0] PAGE_ID = apc_pkg::PAGE_THIS
) (
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire logic       regWrEn,
  input  wire logic       regRdEn,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  output logic      [7:0] regRdData,
  output logic            regRdValid,
  input  wire logic       shortCircuitDet,
  input  wire logic       regulatorSelectPin,
  output logic      [7:0] pagePointer,
  output logic            masterRefEn,
  output logic            porPowerDown,
  output logic            bandgapPowerDown,
  output logic      [1:0] supplyLevelCode,
  output logic            levelShiftPowerDown,
  output logic            dacHighPerf,
  output logic      [2:0] dacProcessingMode,
  output logic            processingModeOne,
  output logic            processingModeTwo,
  output logic            processingModeThreeFour,
  output logic            softStepDisable,
  output logic            softStepDouble,
  output logic            headphonePowerUp,
  output logic            analogInputLeftEn,
  output logic            analogInputRightEn,
  output logic            commonModeLow,
  output logic            headphoneHalfDrive
);
  apc_pkg::apc_state_t state_r;
  apc_pkg::apc_state_t state_nxt;

  logic [1:0] statusSync;
  logic       scSync;
  logic       selSync;
  logic       modeLegal;
  logic [2:0] modeHotIn;

  // Matches an offset on this page, or the pointer itself on any page.
  function automatic logic hit(
    input logic [7:0] addr,
    input logic [7:0] off,
    input logic [7:0] page
  );
    hit = (addr == off) && ((off == apc_pkg::OFF_PAGE) || (page == PAGE_ID));
  endfunction : hit

  // Assembles the read value of one offset, reserved bits at their reset levels.
  function automatic logic [7:0] readValue(
    input apc_pkg::apc_state_t s,
    input logic [7:0]          addr,
    input logic                sc,
    input logic                sel
  );
    logic [7:0] v;
    v = apc_pkg::RST_READ;
    if (hit(addr, apc_pkg::OFF_PAGE, s.page)) begin
      v = s.page;
    end
    if (hit(addr, apc_pkg::OFF_REF, s.page)) begin
      v[apc_pkg::BIT_REF_MASTER] = s.refMaster;
      v[apc_pkg::BIT_REF_POR]    = s.porDown;
      v[apc_pkg::BIT_REF_REGULATOR_BANDGAP]   = s.bgapDown;
    end
    if (hit(addr, apc_pkg::OFF_LDO, s.page)) begin
      v[apc_pkg::LDO_LVL_LSB +: 2] = s.ldoLevel;
      v[apc_pkg::BIT_LDO_LS]       = s.lsDown;
      v[apc_pkg::BIT_LDO_RSVD]     = apc_pkg::RST_LDO_RSVD;
      v[apc_pkg::BIT_LDO_SC]       = sc;
      v[apc_pkg::BIT_REGULATOR_SELECT_PIN]      = sel;
    end
    if (hit(addr, apc_pkg::OFF_PLAY, s.page)) begin
      v[apc_pkg::BIT_PLAY_HP]        = s.dacHighPerf;
      v[apc_pkg::PLAY_MODE_LSB +: 3] = s.mode;
    end
    if (hit(addr, apc_pkg::OFF_GAIN, s.page)) begin
      v[apc_pkg::BIT_GAIN_SSDIS] = s.ssDisable;
      v[apc_pkg::BIT_GAIN_SSDBL] = s.ssDouble;
    end
    if (hit(addr, apc_pkg::OFF_DRV, s.page)) begin
      v[apc_pkg::BIT_DRV_HP]   = s.hpUp;
      v[apc_pkg::BIT_DRV_ANALOG_INPUT_LEFT] = s.ainLeft;
      v[apc_pkg::BIT_DRV_ANALOG_INPUT_RIGHT] = s.ainRight;
    end
    if (hit(addr, apc_pkg::OFF_CM, s.page)) begin
      v[apc_pkg::BIT_CM_LEVEL] = s.cmLow;
      v[apc_pkg::BIT_CM_HALF]  = s.hpHalf;
    end
    readValue = v;
  endfunction : readValue

  apc_sync #(
    .W (2)
  ) u_status_sync (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .asyncIn ({shortCircuitDet, regulatorSelectPin}),
    .syncOut (statusSync)
  );

  assign scSync  = statusSync[1];
  assign selSync = statusSync[0];

  apc_mode_decode u_mode_decode (
    .code   (regWrData[apc_pkg::PLAY_MODE_LSB +: 3]),
    .legal  (modeLegal),
    .oneHot (modeHotIn)
  );

  always_comb begin
    state_nxt         = state_r;
    state_nxt.rdValid = regRdEn;
    if (regRdEn) begin
      state_nxt.rdData = readValue(state_r, regAddr, scSync, selSync);
    end
    if (regWrEn) begin
      if (hit(regAddr, apc_pkg::OFF_PAGE, state_r.page)) begin
        state_nxt.page = regWrData;
      end
      if (hit(regAddr, apc_pkg::OFF_REF, state_r.page)) begin
        state_nxt.refMaster = regWrData[apc_pkg::BIT_REF_MASTER];
        state_nxt.porDown   = regWrData[apc_pkg::BIT_REF_POR];
        state_nxt.bgapDown  = regWrData[apc_pkg::BIT_REF_REGULATOR_BANDGAP];
      end
      if (hit(regAddr, apc_pkg::OFF_LDO, state_r.page)) begin
        state_nxt.ldoLevel = regWrData[apc_pkg::LDO_LVL_LSB +: 2];
        state_nxt.lsDown   = regWrData[apc_pkg::BIT_LDO_LS];
      end
      if (hit(regAddr, apc_pkg::OFF_PLAY, state_r.page)) begin
        state_nxt.dacHighPerf = regWrData[apc_pkg::BIT_PLAY_HP];
        if (modeLegal) begin
          state_nxt.mode    = regWrData[apc_pkg::PLAY_MODE_LSB +: 3];
          state_nxt.modeHot = modeHotIn;
        end
      end
      if (hit(regAddr, apc_pkg::OFF_GAIN, state_r.page)) begin
        state_nxt.ssDisable = regWrData[apc_pkg::BIT_GAIN_SSDIS];
        state_nxt.ssDouble  = regWrData[apc_pkg::BIT_GAIN_SSDBL];
      end
      if (hit(regAddr, apc_pkg::OFF_DRV, state_r.page)) begin
        state_nxt.hpUp     = regWrData[apc_pkg::BIT_DRV_HP];
        state_nxt.ainLeft  = regWrData[apc_pkg::BIT_DRV_ANALOG_INPUT_LEFT];
        state_nxt.ainRight = regWrData[apc_pkg::BIT_DRV_ANALOG_INPUT_RIGHT];
      end
      if (hit(regAddr, apc_pkg::OFF_CM, state_r.page)) begin
        state_nxt.cmLow  = regWrData[apc_pkg::BIT_CM_LEVEL];
        state_nxt.hpHalf = regWrData[apc_pkg::BIT_CM_HALF];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_r             <= '0;
      state_r.page        <= apc_pkg::RST_PAGE;
      state_r.refMaster   <= apc_pkg::RST_CTRL_BIT;
      state_r.porDown     <= apc_pkg::RST_CTRL_BIT;
      state_r.bgapDown    <= apc_pkg::RST_CTRL_BIT;
      state_r.ldoLevel    <= apc_pkg::RST_LDO_LVL;
      state_r.lsDown      <= apc_pkg::RST_LDO_LS;
      state_r.dacHighPerf <= apc_pkg::RST_CTRL_BIT;
      state_r.mode        <= apc_pkg::RST_MODE;
      state_r.modeHot     <= 3'h4;
      state_r.cmLow       <= apc_pkg::RST_CTRL_BIT;
      state_r.rdData      <= apc_pkg::RST_READ;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign regRdData               = state_r.rdData;
  assign regRdValid              = state_r.rdValid;
  assign pagePointer             = state_r.page;
  assign masterRefEn             = state_r.refMaster;
  assign porPowerDown            = state_r.porDown;
  assign bandgapPowerDown        = state_r.bgapDown;
  assign supplyLevelCode         = state_r.ldoLevel;
  assign levelShiftPowerDown     = state_r.lsDown;
  assign dacHighPerf             = state_r.dacHighPerf;
  assign dacProcessingMode       = state_r.mode;
  assign processingModeOne       = state_r.modeHot[0];
  assign processingModeTwo       = state_r.modeHot[1];
  assign processingModeThreeFour = state_r.modeHot[2];
  assign softStepDisable         = state_r.ssDisable;
  assign softStepDouble          = state_r.ssDouble;
  assign headphonePowerUp        = state_r.hpUp;
  assign analogInputLeftEn       = state_r.ainLeft;
  assign analogInputRightEn      = state_r.ainRight;
  assign commonModeLow           = state_r.cmLow;
  assign headphoneHalfDrive      = state_r.hpHalf;

  // Checks that tie control outputs to the writes that set them; levelShiftPowerDown and the mode outputs are not tied to writes.
  logic onPage;
  assign onPage = (state_r.page == PAGE_ID);

  property p_page_write;
    @(posedge sys_clk) disable iff (!resetn)
    regWrEn && regAddr == apc_pkg::OFF_PAGE |=> pagePointer == $past(regWrData);
  endproperty
  a_page_write: assert property (p_page_write) else $error("page pointer not written");

  property p_off_page;
    @(posedge sys_clk) disable iff (!resetn)
    regWrEn && regAddr != apc_pkg::OFF_PAGE && !onPage
      |=> $stable(masterRefEn) && $stable(headphonePowerUp) && $stable(analogInputLeftEn)
          && $stable(analogInputRightEn);
  endproperty
  a_off_page: assert property (p_off_page) else $error("write on other page took effect");

  property p_ref_master;
    @(posedge sys_clk) disable iff (!resetn)
    regWrEn && regAddr == apc_pkg::OFF_REF && onPage
      |=> masterRefEn == $past(regWrData[apc_pkg::BIT_REF_MASTER]);
  endproperty
  a_ref_master: assert property (p_ref_master) else $error("master reference wrong");

  property p_ref_por;
    @(posedge sys_clk) disable iff (!resetn)
    regWrEn && regAddr == apc_pkg::OFF_REF && onPage
      |=> porPowerDown == $past(regWrData[apc_pkg::BIT_REF_POR]);
  endproperty
  a_ref_por: assert property (p_ref_por) else $error("reset circuit control wrong");

  property p_ref_regulator_bandgap;
    @(posedge sys_clk) disable iff (!resetn)
    regWrEn && regAddr == apc_pkg::OFF_REF && onPage
      |=> bandgapPowerDown == $past(regWrData[apc_pkg::BIT_REF_REGULATOR_BANDGAP]);
  endproperty
  a_ref_regulator_bandgap: assert property (p_ref_regulator_bandgap) else $error("bandgap control wrong");

  property p_ldo_level;
    @(posedge sys_clk) disable iff (!resetn)
    regWrEn && regAddr == apc_pkg::OFF_LDO && onPage
      |=> supplyLevelCode == $past(regWrData[apc_pkg::LDO_LVL_LSB +: 2]);
  endproperty
  a_ldo_level: assert property (p_ldo_level) else $error("supply level wrong");

  property p_ls_reset;
    @(posedge sys_clk)
    !resetn |=> levelShiftPowerDown && !masterRefEn && pagePointer == apc_pkg::RST_PAGE;
  endproperty
  a_ls_reset: assert property (p_ls_reset) else $error("reset values wrong");

  property p_short_read;
    @(posedge sys_clk) disable iff (!resetn)
    regRdEn && regAddr == apc_pkg::OFF_LDO && onPage
      |=> regRdValid && regRdData[apc_pkg::BIT_LDO_SC] == $past(scSync)
          && regRdData[apc_pkg::BIT_LDO_RSVD];
  endproperty
  a_short_read: assert property (p_short_read) else $error("short circuit status wrong");

  property p_sel_read;
    @(posedge sys_clk) disable iff (!resetn)
    regulatorSelectPin ##1 regulatorSelectPin ##1 (regulatorSelectPin && regRdEn
      && regAddr == apc_pkg::OFF_LDO && onPage) |=> regRdData[apc_pkg::BIT_REGULATOR_SELECT_PIN];
  endproperty
  a_sel_read: assert property (p_sel_read) else $error("select pin status wrong");

  property p_play_perf;
    @(posedge sys_clk) disable iff (!resetn)
    regWrEn && regAddr == apc_pkg::OFF_PLAY && onPage
      |=> dacHighPerf == $past(regWrData[apc_pkg::BIT_PLAY_HP]);
  endproperty
  a_play_perf: assert property (p_play_perf) else $error("DAC power mode wrong");

  property p_mode_legal;
    @(posedge sys_clk) disable iff (!resetn)
    dacProcessingMode <= apc_pkg::MODE_P1
      && $onehot({processingModeOne, processingModeTwo, processingModeThreeFour});
  endproperty
  a_mode_legal: assert property (p_mode_legal) else $error("illegal processing mode");

  property p_gain_ss;
    @(posedge sys_clk) disable iff (!resetn)
    regWrEn && regAddr == apc_pkg::OFF_GAIN && onPage
      |=> softStepDisable == $past(regWrData[apc_pkg::BIT_GAIN_SSDIS]);
  endproperty
  a_gain_ss: assert property (p_gain_ss) else $error("soft-step disable wrong");

  property p_gain_dbl;
    @(posedge sys_clk) disable iff (!resetn)
    regWrEn && regAddr == apc_pkg::OFF_GAIN && onPage
      |=> softStepDouble == $past(regWrData[apc_pkg::BIT_GAIN_SSDBL]);
  endproperty
  a_gain_dbl: assert property (p_gain_dbl) else $error("soft-step doubling wrong");

  property p_drv;
    @(posedge sys_clk) disable iff (!resetn)
    regWrEn && regAddr == apc_pkg::OFF_DRV && onPage
      |=> headphonePowerUp == $past(regWrData[apc_pkg::BIT_DRV_HP]);
  endproperty
  a_drv: assert property (p_drv) else $error("headphone power wrong");

  property p_ain;
    @(posedge sys_clk) disable iff (!resetn)
    regWrEn && regAddr == apc_pkg::OFF_DRV && onPage
      |=> analogInputLeftEn == $past(regWrData[apc_pkg::BIT_DRV_ANALOG_INPUT_LEFT])
          && analogInputRightEn == $past(regWrData[apc_pkg::BIT_DRV_ANALOG_INPUT_RIGHT]);
  endproperty
  a_ain: assert property (p_ain) else $error("analog input enable wrong");

  property p_cm;
    @(posedge sys_clk) disable iff (!resetn)
    regWrEn && regAddr == apc_pkg::OFF_CM && onPage
      |=> commonModeLow == $past(regWrData[apc_pkg::BIT_CM_LEVEL])
          && headphoneHalfDrive == $past(regWrData[apc_pkg::BIT_CM_HALF]);
  endproperty
  a_cm: assert property (p_cm) else $error("common-mode control wrong");

  property p_readback;
    @(posedge sys_clk) disable iff (!resetn)
    (regWrEn && regAddr == apc_pkg::OFF_DRV && onPage) ##1 !regWrEn ##1 (regRdEn && !regWrEn
      && regAddr == apc_pkg::OFF_DRV && onPage)
      |=> regRdData == ($past(regWrData, 3) & 8'h23);
  endproperty
  a_readback: assert property (p_readback) else $error("read back differs");

  c_page_switch: cover property (@(posedge sys_clk) disable iff (!resetn)
    regWrEn && regAddr == apc_pkg::OFF_PAGE ##1 onPage);
  c_bad_mode: cover property (@(posedge sys_clk) disable iff (!resetn)
    regWrEn && regAddr == apc_pkg::OFF_PLAY && onPage && !modeLegal);
  c_short: cover property (@(posedge sys_clk) disable iff (!resetn)
    regRdValid && regRdData[apc_pkg::BIT_LDO_SC]);
endmodule : apc_regs

//--- hw/apc_sync.sv
// Two-stage synchroniser for levels that arrive from outside the clock domain.
`timescale 1ns/100ps
module apc_sync #(
  parameter int W = 2
) (
  input  wire logic         sys_clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);
  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } apc_sync_t;

  apc_sync_t state_r;
  apc_sync_t state_nxt;

  always_comb begin
    state_nxt        = state_r;
    state_nxt.stage1 = asyncIn;
    state_nxt.stage2 = state_r.stage1;
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign syncOut = state_r.stage2;
endmodule : apc_sync

//--- tb/tb_top.sv
// Self-checking testbench of the power control page register bank.
`timescale 1ns/100ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin err_count++; \
  $display("[ERR] %0t mismatch got %h exp %h", $time, (got), (exp)); end end

module tb_top;
  localparam logic [7:0] MASK [0:10] = '{8'hFF, 8'h1A, 8'h38, 8'h3C, 8'h00, 8'h00, 8'h00,
                                         8'h00, 8'hC0, 8'h23, 8'h44};
  logic       sys_clk;
  logic       resetn;
  logic       regWrEn;
  logic       regRdEn;
  logic [7:0] regAddr;
  logic [7:0] regWrData;
  logic [7:0] regRdData;
  logic       regRdValid;
  logic       shortCircuitDet;
  logic       regulatorSelectPin;
  logic [7:0] pagePointer;
  logic       masterRefEn;
  logic       porPowerDown;
  logic       bandgapPowerDown;
  logic [1:0] supplyLevelCode;
  logic       levelShiftPowerDown;
  logic       dacHighPerf;
  logic [2:0] dacProcessingMode;
  logic       processingModeOne;
  logic       processingModeTwo;
  logic       processingModeThreeFour;
  logic       softStepDisable;
  logic       softStepDouble;
  logic       headphonePowerUp;
  logic       analogInputLeftEn;
  logic       analogInputRightEn;
  logic       commonModeLow;
  logic       headphoneHalfDrive;
  logic [7:0] mdl [0:10];
  logic [7:0] page;
  logic [7:0] expQ [$];
  logic [7:0] expHead;
  logic [7:0] a;
  logic [7:0] d;
  int         err_count;
  int         checks;

  apc_regs apc_regs_inst (
    .sys_clk(sys_clk), .resetn(resetn), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .regRdValid(regRdValid), .shortCircuitDet(shortCircuitDet),
    .regulatorSelectPin(regulatorSelectPin), .pagePointer(pagePointer),
    .masterRefEn(masterRefEn), .porPowerDown(porPowerDown),
    .bandgapPowerDown(bandgapPowerDown), .supplyLevelCode(supplyLevelCode),
    .levelShiftPowerDown(levelShiftPowerDown), .dacHighPerf(dacHighPerf),
    .dacProcessingMode(dacProcessingMode), .processingModeOne(processingModeOne),
    .processingModeTwo(processingModeTwo),
    .processingModeThreeFour(processingModeThreeFour),
    .softStepDisable(softStepDisable), .softStepDouble(softStepDouble),
    .headphonePowerUp(headphonePowerUp), .analogInputLeftEn(analogInputLeftEn),
    .analogInputRightEn(analogInputRightEn), .commonModeLow(commonModeLow),
    .headphoneHalfDrive(headphoneHalfDrive)
  );

  always #5 sys_clk = ~sys_clk;

  task automatic print_verdict;
    $display("Comparisons %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  // Expected read value, with the reserved regulator bit reading one.
  function automatic logic [7:0] exp_rd(input logic [7:0] adr);
    logic [7:0] v;
    v = 8'h00;
    if (adr == apc_pkg::OFF_PAGE) v = page;
    else if (page == apc_pkg::PAGE_THIS && adr <= apc_pkg::OFF_CM) v = mdl[adr[3:0]];
    if (adr == apc_pkg::OFF_LDO && page == apc_pkg::PAGE_THIS) begin
      v = v | {5'h01, shortCircuitDet, regulatorSelectPin};
    end
    return v;
  endfunction : exp_rd

  task automatic model_wr(input logic [7:0] adr, input logic [7:0] dat);
    if (adr == apc_pkg::OFF_PAGE) page = dat;
    else if (page == apc_pkg::PAGE_THIS && adr <= apc_pkg::OFF_CM) begin
      if (adr == apc_pkg::OFF_PLAY && dat[4:2] > apc_pkg::MODE_P1) mdl[3][5] = dat[5];
      else mdl[adr[3:0]] = dat & MASK[adr[3:0]];
    end
  endtask : model_wr

  task automatic model_rst;
    page = apc_pkg::RST_PAGE;
    foreach (mdl[i]) mdl[i] = 8'h00;
    mdl[2] = 8'h08;
  endtask : model_rst

  // One register cycle; a read notes the value from before a write in the same cycle.
  task automatic access(input logic w, input logic r, input logic [7:0] adr,
                        input logic [7:0] dat);
    @(posedge sys_clk);
    #1;
    regWrEn = w;
    regRdEn = r;
    regAddr = adr;
    regWrData = dat;
    if (r) expQ.push_back(exp_rd(adr));
    if (w) model_wr(adr, dat);
    @(posedge sys_clk);
    #1;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
  endtask : access

  task automatic chk_outs;
    `CHK(pagePointer, page)
    `CHK(masterRefEn, mdl[1][4])
    `CHK(porPowerDown, mdl[1][3])
    `CHK(bandgapPowerDown, mdl[1][1])
    `CHK(supplyLevelCode, mdl[2][5:4])
    `CHK(levelShiftPowerDown, mdl[2][3])
    `CHK(dacHighPerf, mdl[3][5])
    `CHK(dacProcessingMode, mdl[3][4:2])
    `CHK(processingModeOne, mdl[3][4:2] == apc_pkg::MODE_P1)
    `CHK(processingModeTwo, mdl[3][4:2] == apc_pkg::MODE_P2)
    `CHK(processingModeThreeFour, mdl[3][4:2] == apc_pkg::MODE_P34)
    `CHK(softStepDisable, mdl[8][7])
    `CHK(softStepDouble, mdl[8][6])
    `CHK(headphonePowerUp, mdl[9][5])
    `CHK(analogInputLeftEn, mdl[9][1])
    `CHK(analogInputRightEn, mdl[9][0])
    `CHK(commonModeLow, mdl[10][6])
    `CHK(headphoneHalfDrive, mdl[10][2])
  endtask : chk_outs

  // Each read answer is compared with the oldest noted value.
  always @(negedge sys_clk) begin
    if (regRdValid === 1'b1) begin
      if (expQ.size() == 0) begin
        err_count++;
        $display("[ERR] %0t read answer without a request", $time);
      end else begin
        expHead = expQ.pop_front();
        `CHK(regRdData, expHead)
      end
    end
  end

  initial begin
    repeat (5000) @(posedge sys_clk);
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    print_verdict();
  end

  initial begin
    void'($urandom(32'h7862802E));
    sys_clk = 1'b0;
    resetn = 1'b0;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    shortCircuitDet = 1'b0;
    regulatorSelectPin = 1'b0;
    err_count = 0;
    checks = 0;
    model_rst();
    repeat (10) @(posedge sys_clk);
    #1;
    resetn = 1'b1;
    chk_outs();
    access(1'b0, 1'b1, apc_pkg::OFF_LDO, 8'h00);
    access(1'b1, 1'b0, apc_pkg::OFF_PAGE, apc_pkg::PAGE_THIS);
    for (int i = 0; i < 12; i++) access(1'b0, 1'b1, i[7:0], 8'h00);
    access(1'b0, 1'b1, 8'hFF, 8'h00);
    repeat (40) begin
      a = 8'($urandom_range(1, 10));
      d = (8'($urandom) & MASK[a[3:0]]) | ((a == apc_pkg::OFF_LDO) ? 8'h04 : 8'h00);
      if (a == apc_pkg::OFF_PLAY && d[4:2] > apc_pkg::MODE_P1) d[4:2] = apc_pkg::MODE_P1;
      access(1'b1, 1'($urandom), a, d);
      access(1'b0, 1'b1, a, 8'h00);
    end
    chk_outs();
    // Every mode code and supply level; the upper mode codes are refused.
    for (int m = 0; m < 8; m++) begin
      access(1'b1, 1'b0, apc_pkg::OFF_PLAY, {2'h0, m[0], m[2:0], 2'h0});
      access(1'b1, 1'b1, apc_pkg::OFF_LDO, {2'h0, m[1:0], m[2], 3'h4});
      chk_outs();
    end
    repeat (4) begin
      shortCircuitDet = 1'($urandom);
      regulatorSelectPin = 1'($urandom);
      repeat (3) @(posedge sys_clk);
      access(1'b1, 1'b1, apc_pkg::OFF_LDO, 8'h0C);
    end
    access(1'b1, 1'b0, apc_pkg::OFF_DRV, 8'h00);
    access(1'b1, 1'b0, apc_pkg::OFF_PAGE, 8'($urandom_range(2, 255)));
    access(1'b1, 1'b1, apc_pkg::OFF_DRV, 8'h23);
    chk_outs();
    access(1'b1, 1'b0, apc_pkg::OFF_PAGE, apc_pkg::PAGE_THIS);
    access(1'b1, 1'b1, apc_pkg::OFF_DRV, 8'h23);
    access(1'b0, 1'b1, apc_pkg::OFF_DRV, 8'h00);
    chk_outs();
    @(posedge sys_clk);
    #1;
    resetn = 1'b0;
    @(posedge sys_clk);
    #1;
    resetn = 1'b1;
    model_rst();
    chk_outs();
    access(1'b0, 1'b1, apc_pkg::OFF_PAGE, 8'h00);
    repeat (4) @(posedge sys_clk);
    `CHK(expQ.size(), 0)
    print_verdict();
  end
endmodule : tb_top
